// ---- hdl/rzct_pkg.sv ----
// constants, types and helpers shared by the remote zero and calibration trigger
package rzct_pkg;

	// clock and timing base
	localparam int unsigned CLK_KHZ    = 100000;                 // system clock rate in kHz (100 MHz)
	localparam int unsigned POLL_MS    = 100;                    // input poll period in ms
	localparam int unsigned SAMPLE_MS  = 50;                     // measurement sample period in ms
	localparam int unsigned MS_PER_S   = 1000;                   // ms in one second
	localparam int unsigned POLL_CYC   = POLL_MS * CLK_KHZ;      // clock cycles per poll
	localparam int unsigned SAMPLE_CYC = SAMPLE_MS * CLK_KHZ;    // clock cycles per sample period
	localparam int unsigned TICK_W     = 24;                     // width of the tick dividers
	localparam int unsigned CNT_W      = 12;                     // width of wait and run counters
	localparam int unsigned AVG_W      = 11;                     // width of the average count input
	localparam int unsigned MAX_AVG    = 1024;                   // deepest averaging allowed

	// sensor family codes
	localparam logic [1:0] SENS_THERM = 2'h0;                    // thermocouple family
	localparam logic [1:0] SENS_DIODE = 2'h1;                    // wide dynamic range diode family
	localparam logic [1:0] SENS_NEW   = 2'h2;                    // newer family, internal tables
	localparam logic [1:0] SENS_NEWCF = 2'h3;                    // newer family, table driven

	// zero time per sensor, in seconds
	localparam int unsigned ZERO_S_THERM = 10;
	localparam int unsigned ZERO_S_DIODE = 12;
	localparam int unsigned ZERO_S_NEW   = 20;
	localparam int unsigned ZERO_S_NEWCF = 8;
	// calibration time per channel, in seconds
	localparam int unsigned CAL_S_THERM  = 6;
	localparam int unsigned CAL_S_DIODE  = 7;
	localparam int unsigned CAL_S_NEW    = 9;
	localparam int unsigned CAL_S_NEWCF  = 6;

	// polled pin pair {in1, in2} as levels on the pins, low means asserted
	localparam logic [1:0] LVL_NONE  = 2'h3;
	localparam logic [1:0] LVL_CAL_A = 2'h2;
	localparam logic [1:0] LVL_ZERO  = 2'h1;
	localparam logic [1:0] LVL_CAL_B = 2'h0;

	localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;             // last count of a wait or run
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

	// decoded request kinds
	typedef enum logic [1:0] {
		RZCT_REQ_NONE  = 2'b00,
		RZCT_REQ_CAL_A = 2'b01,
		RZCT_REQ_ZERO  = 2'b10,
		RZCT_REQ_CAL_B = 2'b11
	} rzct_req_e;

	// sequencer states
	typedef enum logic [1:0] {
		RZCT_ST_IDLE = 2'b00,
		RZCT_ST_WAIT = 2'b01,
		RZCT_ST_RUN  = 2'b10
	} rzct_state_e;

	// seconds to sample ticks
	function automatic logic [CNT_W-1:0] rzct_ticks(input int unsigned sec);
		rzct_ticks = CNT_W'(sec * MS_PER_S / SAMPLE_MS);
	endfunction

	// pin pair to request kind
	function automatic rzct_req_e rzct_decode(input logic [1:0] lvl);
		if (lvl == LVL_CAL_A) begin
			rzct_decode = RZCT_REQ_CAL_A;
		end else if (lvl == LVL_ZERO) begin
			rzct_decode = RZCT_REQ_ZERO;
		end else if (lvl == LVL_CAL_B) begin
			rzct_decode = RZCT_REQ_CAL_B;
		end else begin
			rzct_decode = RZCT_REQ_NONE;
		end
	endfunction

	// zero ticks for one sensor family
	function automatic logic [CNT_W-1:0] rzct_zero_ticks(input logic [1:0] typ);
		case (typ)
			SENS_THERM: rzct_zero_ticks = rzct_ticks(ZERO_S_THERM);
			SENS_DIODE: rzct_zero_ticks = rzct_ticks(ZERO_S_DIODE);
			SENS_NEW:   rzct_zero_ticks = rzct_ticks(ZERO_S_NEW);
			default:    rzct_zero_ticks = rzct_ticks(ZERO_S_NEWCF);
		endcase
	endfunction

	// calibration ticks for one sensor family
	function automatic logic [CNT_W-1:0] rzct_cal_ticks(input logic [1:0] typ);
		case (typ)
			SENS_THERM: rzct_cal_ticks = rzct_ticks(CAL_S_THERM);
			SENS_DIODE: rzct_cal_ticks = rzct_ticks(CAL_S_DIODE);
			SENS_NEW:   rzct_cal_ticks = rzct_ticks(CAL_S_NEW);
			default:    rzct_cal_ticks = rzct_ticks(CAL_S_NEWCF);
		endcase
	endfunction

endpackage

// ---- hdl/rzct_tick.sv ----
// periodic one-cycle tick divider
`timescale 1ns/100ps
module rzct_tick #(
	parameter int unsigned PERIOD = rzct_pkg::SAMPLE_CYC    // cycles between ticks
) (
	input  wire logic i_clk_sys,                             // system clock
	input  wire logic i_rst,                                 // synchronous reset, high
	output logic      o_tick                                 // one-cycle pulse each period
);

	localparam logic [rzct_pkg::TICK_W-1:0] LAST = rzct_pkg::TICK_W'(PERIOD - 1);

	logic [rzct_pkg::TICK_W-1:0] cnt_r;                     // cycles since last tick

	// free running divider, wraps at the period
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			cnt_r <= '0;
		end else if (cnt_r == LAST) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// tick straight from a flop, one cycle wide
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= (cnt_r == LAST);
		end
	end

endmodule

// ---- hdl/rzct_trigger.sv ----
// remote zero and calibration trigger: polls two low-active pins and sequences the cycles
`timescale 1ns/100ps
module rzct_trigger #(
	parameter int unsigned POLL_CYC   = rzct_pkg::POLL_CYC,    // cycles per input poll
	parameter int unsigned SAMPLE_CYC = rzct_pkg::SAMPLE_CYC   // cycles per sample period
) (
	input  wire logic                       i_clk_sys,         // system clock
	input  wire logic                       i_rst,             // synchronous reset, high
	input  wire logic                       i_rmt_in1_n,       // remote input 1, low active pin
	input  wire logic                       i_rmt_in2_n,       // remote input 2, low active pin
	input  wire logic                       i_free_run,        // free run measurement mode
	input  wire logic [rzct_pkg::AVG_W-1:0] i_avg_count,       // averages per reading, 1 to 1024
	input  wire logic                       i_sens_present_a,  // sensor attached on channel A
	input  wire logic                       i_sens_present_b,  // sensor attached on channel B
	input  wire logic [1:0]                 i_sens_type_a,     // sensor family on channel A
	input  wire logic [1:0]                 i_sens_type_b,     // sensor family on channel B
	output logic                            o_busy,            // zero or calibration running
	output logic                            o_ref_enable,      // reference power output on
	output logic                            o_zero_active,     // zero both running
	output logic                            o_cal_a_active,    // channel A calibration running
	output logic                            o_cal_b_active,    // channel B calibration running
	output logic                            o_req_pending,     // request accepted, not yet started
	output logic                            o_cycle_done       // one-cycle pulse at cycle end
);

	logic [1:0]                 meta_r;                        // first synchroniser stage
	logic [1:0]                 sync_r;                        // second stage, {in1, in2}
	logic [1:0]                 poll_lvl_r;                    // pin pair seen at last poll
	logic                       poll_tick;                     // poll period pulse
	logic                       sample_tick;                   // sample period pulse
	logic                       new_req;                       // fresh request at this poll
	rzct_pkg::rzct_req_e        new_kind;                      // kind decoded at this poll
	logic                       pend_r;                        // request waiting to be taken
	rzct_pkg::rzct_req_e        pend_kind_r;                   // kind of waiting request
	rzct_pkg::rzct_state_e      state_r;                       // sequencer state
	rzct_pkg::rzct_state_e      state_nxt;
	rzct_pkg::rzct_req_e        kind_r;                        // kind of current cycle
	rzct_pkg::rzct_req_e        kind_nxt;
	logic [rzct_pkg::CNT_W-1:0] wait_cnt_r;                    // sample ticks left to wait
	logic [rzct_pkg::CNT_W-1:0] wait_cnt_nxt;
	logic [rzct_pkg::CNT_W-1:0] run_cnt_r;                     // sample ticks left to run
	logic [rzct_pkg::CNT_W-1:0] run_cnt_nxt;
	logic                       consume;                       // pending request taken now
	logic                       done_nxt;                      // cycle ends this edge
	logic [rzct_pkg::CNT_W-1:0] wait_load;                     // wait length for a new request
	logic [rzct_pkg::CNT_W-1:0] zero_len;                      // zero both length
	logic [rzct_pkg::CNT_W-1:0] zero_a;
	logic [rzct_pkg::CNT_W-1:0] zero_b;

	// time bases: the poll rate sets request timing, the sample rate sets cycle timing
	rzct_tick #(.PERIOD(POLL_CYC)) u_poll (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.o_tick    (poll_tick)
	);

	rzct_tick #(.PERIOD(SAMPLE_CYC)) u_sample (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.o_tick    (sample_tick)
	);

	// two-stage synchroniser; only the second stage feeds logic
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			meta_r <= rzct_pkg::LVL_NONE;
			sync_r <= rzct_pkg::LVL_NONE;
		end else begin
			meta_r <= {i_rmt_in1_n, i_rmt_in2_n};
			sync_r <= meta_r;
		end
	end

	// sample the pins only at the poll; a level between polls is never seen
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			poll_lvl_r <= rzct_pkg::LVL_NONE;
		end else if (poll_tick) begin
			poll_lvl_r <= sync_r;
		end
	end

	// a request counts once per change, so a held level does not retrigger
	always_comb begin
		new_kind = rzct_pkg::rzct_decode(sync_r);
		new_req  = poll_tick && (new_kind != rzct_pkg::RZCT_REQ_NONE) && (sync_r != poll_lvl_r);
	end

	// wait length: one sample in free run, else the averaging time; zero read as one
	always_comb begin
		if (i_free_run || (i_avg_count == '0)) begin
			wait_load = rzct_pkg::CNT_ONE;
		end else if (i_avg_count > rzct_pkg::AVG_W'(rzct_pkg::MAX_AVG)) begin
			wait_load = rzct_pkg::CNT_W'(rzct_pkg::MAX_AVG);
		end else begin
			wait_load = rzct_pkg::CNT_W'(i_avg_count);
		end
	end

	// zero both runs per attached sensor; with none attached it still lasts one sample
	always_comb begin
		zero_a   = i_sens_present_a ? rzct_pkg::rzct_zero_ticks(i_sens_type_a) : rzct_pkg::CNT_ZERO;
		zero_b   = i_sens_present_b ? rzct_pkg::rzct_zero_ticks(i_sens_type_b) : rzct_pkg::CNT_ZERO;
		zero_len = zero_a + zero_b;
		if (zero_len == rzct_pkg::CNT_ZERO) begin
			zero_len = rzct_pkg::CNT_ONE;
		end
	end

	// sequencer next state
	always_comb begin
		state_nxt    = state_r;
		kind_nxt     = kind_r;
		wait_cnt_nxt = wait_cnt_r;
		run_cnt_nxt  = run_cnt_r;
		consume      = 1'b0;
		done_nxt     = 1'b0;
		case (state_r)
			rzct_pkg::RZCT_ST_IDLE: begin
				// take the waiting request and let the averaging period run out
				if (pend_r) begin
					state_nxt    = rzct_pkg::RZCT_ST_WAIT;
					kind_nxt     = pend_kind_r;
					wait_cnt_nxt = wait_load;
					consume      = 1'b1;
				end
			end
			rzct_pkg::RZCT_ST_WAIT: begin
				if (sample_tick) begin
					if (wait_cnt_r <= rzct_pkg::CNT_ONE) begin
						state_nxt = rzct_pkg::RZCT_ST_RUN;
						if (kind_r == rzct_pkg::RZCT_REQ_ZERO) begin
							run_cnt_nxt = zero_len;
						end else if (kind_r == rzct_pkg::RZCT_REQ_CAL_A) begin
							run_cnt_nxt = rzct_pkg::rzct_cal_ticks(i_sens_type_a);
						end else begin
							run_cnt_nxt = rzct_pkg::rzct_cal_ticks(i_sens_type_b);
						end
					end else begin
						wait_cnt_nxt = wait_cnt_r - 1'b1;
					end
				end
			end
			rzct_pkg::RZCT_ST_RUN: begin
				if (sample_tick) begin
					if (run_cnt_r <= rzct_pkg::CNT_ONE) begin
						done_nxt = 1'b1;
						// a request queued behind a running cycle starts as soon as it ends
						if (pend_r) begin
							state_nxt = rzct_pkg::RZCT_ST_RUN;
							kind_nxt  = pend_kind_r;
							consume   = 1'b1;
							if (pend_kind_r == rzct_pkg::RZCT_REQ_ZERO) begin
								run_cnt_nxt = zero_len;
							end else if (pend_kind_r == rzct_pkg::RZCT_REQ_CAL_A) begin
								run_cnt_nxt = rzct_pkg::rzct_cal_ticks(i_sens_type_a);
							end else begin
								run_cnt_nxt = rzct_pkg::rzct_cal_ticks(i_sens_type_b);
							end
						end else begin
							state_nxt = rzct_pkg::RZCT_ST_IDLE;
						end
					end else begin
						run_cnt_nxt = run_cnt_r - 1'b1;
					end
				end
			end
			default: begin
				state_nxt = rzct_pkg::RZCT_ST_IDLE;
			end
		endcase
	end

	// pending request; a new one in the taking cycle wins over the clear
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pend_r      <= 1'b0;
			pend_kind_r <= rzct_pkg::RZCT_REQ_NONE;
		end else if (new_req) begin
			pend_r      <= 1'b1;
			pend_kind_r <= new_kind;
		end else if (consume) begin
			pend_r      <= 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_r    <= rzct_pkg::RZCT_ST_IDLE;
			kind_r     <= rzct_pkg::RZCT_REQ_NONE;
			wait_cnt_r <= rzct_pkg::CNT_ZERO;
			run_cnt_r  <= rzct_pkg::CNT_ZERO;
		end else begin
			state_r    <= state_nxt;
			kind_r     <= kind_nxt;
			wait_cnt_r <= wait_cnt_nxt;
			run_cnt_r  <= run_cnt_nxt;
		end
	end

	// status outputs from flops, built from next state so they line up with it
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_busy         <= 1'b0;
			o_ref_enable   <= 1'b0;
			o_zero_active  <= 1'b0;
			o_cal_a_active <= 1'b0;
			o_cal_b_active <= 1'b0;
			o_req_pending  <= 1'b0;
			o_cycle_done   <= 1'b0;
		end else begin
			o_busy         <= (state_nxt == rzct_pkg::RZCT_ST_RUN);
			o_ref_enable   <= (state_nxt == rzct_pkg::RZCT_ST_RUN) && kind_nxt[0];
			o_zero_active  <= (state_nxt == rzct_pkg::RZCT_ST_RUN) && (kind_nxt == rzct_pkg::RZCT_REQ_ZERO);
			o_cal_a_active <= (state_nxt == rzct_pkg::RZCT_ST_RUN) && (kind_nxt == rzct_pkg::RZCT_REQ_CAL_A);
			o_cal_b_active <= (state_nxt == rzct_pkg::RZCT_ST_RUN) && (kind_nxt == rzct_pkg::RZCT_REQ_CAL_B);
			o_req_pending  <= new_req || (pend_r && !consume) || (state_nxt == rzct_pkg::RZCT_ST_WAIT);
			o_cycle_done   <= done_nxt;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	ref_only_cal_a: assert property (o_ref_enable |-> (o_cal_a_active || o_cal_b_active) && o_busy)
		else $error("reference on outside a calibration");
	cal_needs_ref_a: assert property ((o_cal_a_active || o_cal_b_active) |-> o_ref_enable)
		else $error("calibration running without reference");
	busy_whole_a: assert property (o_busy && !o_cycle_done ##1 !o_busy |-> o_cycle_done)
		else $error("busy dropped without cycle end");
	poll_hold_a: assert property (!poll_tick |=> $stable(poll_lvl_r))
		else $error("pins sampled off the poll");
	idle_pins_a: assert property (poll_tick && sync_r == rzct_pkg::LVL_NONE && !pend_r |=> !pend_r)
		else $error("request taken from idle pins");
	decode_cal_a: assert property (new_req && sync_r == rzct_pkg::LVL_CAL_A |=> pend_kind_r == rzct_pkg::RZCT_REQ_CAL_A)
		else $error("wrong decode for channel A calibration");
	decode_zero_a: assert property (new_req && sync_r == rzct_pkg::LVL_ZERO |=> pend_kind_r == rzct_pkg::RZCT_REQ_ZERO)
		else $error("wrong decode for zero both");
	free_run_a: assert property (state_r == rzct_pkg::RZCT_ST_IDLE && pend_r && i_free_run |=> wait_cnt_r == rzct_pkg::CNT_ONE)
		else $error("free run wait not one sample");
	start_gate_a: assert property (state_r == rzct_pkg::RZCT_ST_WAIT && !(sample_tick && wait_cnt_r <= rzct_pkg::CNT_ONE) |=> !o_busy)
		else $error("cycle started before wait ran out");
	sync_path_a: assert property (sync_r == $past(meta_r))
		else $error("synchroniser stage skipped");
	cal_len_a: assert property ($rose(o_cal_a_active) |-> run_cnt_r == rzct_pkg::rzct_cal_ticks($past(i_sens_type_a)))
		else $error("calibration length wrong");

	zero_run_c: cover property ($rose(o_zero_active));
	cal_a_run_c: cover property ($rose(o_cal_a_active));
	cal_b_run_c: cover property ($rose(o_cal_b_active));
	queued_c: cover property (o_cycle_done && o_busy);

endmodule

// ---- test/rzct_ctrl_model.sv ----
// model of the external controller that drives the two remote pins
`timescale 1ns/100ps
module rzct_ctrl_model #(
	parameter int unsigned HOLD_CYC = 40             // cycles each level is held, two polls at sim rate
) (
	input  wire logic       i_clk_sys,               // system clock
	input  wire logic       i_go,                    // start one request
	input  wire logic [1:0] i_code,                  // pin pair {in1, in2} to drive
	output logic            o_in1_n,                 // remote pin 1, low active
	output logic            o_in2_n,                 // remote pin 2, low active
	output logic            o_idle                   // ready for the next request
);
	int unsigned cnt_r = 0;                          // cycles left in the request
	logic [1:0]  lvl_r = 2'h3;                       // level on the pins, released means pulled high

	// hold the request a full poll and more, then return to the released level
	// so that two identical requests in a row are still seen as two changes
	always @(posedge i_clk_sys) begin
		if (i_go) begin
			cnt_r <= 2 * HOLD_CYC;
			lvl_r <= i_code;                         // any code is sent as given, the released level 2'h3 included
		end else if (cnt_r != 0) begin
			cnt_r <= cnt_r - 1;
			if (cnt_r == HOLD_CYC + 1) begin
				lvl_r <= 2'h3;                       // level held for at least one poll
			end
		end
	end

	// pins are low when asserted, pulled high when released
	assign o_in1_n = lvl_r[1];
	assign o_in2_n = lvl_r[0];
	assign o_idle  = (cnt_r == 0);
endmodule

// ---- test/rzct_trigger_bench.sv ----
// self-checking testbench of the remote zero and calibration trigger
`timescale 1ns/100ps
module rzct_trigger_bench;
	localparam int unsigned POLL = 20;                // shortened poll period
	localparam int unsigned SAMP = 10;                // shortened sample period
	localparam int unsigned TPS  = rzct_pkg::MS_PER_S / rzct_pkg::SAMPLE_MS;  // sample ticks per second

	logic                       clk;                  // system clock
	logic                       rst;                  // synchronous reset
	logic                       in1_n;                // pin 1 from the model
	logic                       in2_n;                // pin 2 from the model
	logic                       free_run;             // free run mode
	logic [rzct_pkg::AVG_W-1:0] avg;                  // average count
	logic                       pres_a;               // sensor on channel A
	logic                       pres_b;               // sensor on channel B
	logic [1:0]                 typ_a;                // family on channel A
	logic [1:0]                 typ_b;                // family on channel B
	logic                       go;                   // model start strobe
	logic [1:0]                 code;                 // model pin pair
	logic                       idle;                 // model ready
	logic                       busy;
	logic                       ref_en;
	logic                       zero_act;
	logic                       cal_a_act;
	logic                       cal_b_act;
	logic                       pend;
	logic                       done;
	int                         n_errors = 0;         // mismatches seen
	int                         num_checks = 0;       // comparisons made

	rzct_trigger #(.POLL_CYC(POLL), .SAMPLE_CYC(SAMP)) dut (
		.i_clk_sys(clk), .i_rst(rst), .i_rmt_in1_n(in1_n), .i_rmt_in2_n(in2_n),
		.i_free_run(free_run), .i_avg_count(avg), .i_sens_present_a(pres_a),
		.i_sens_present_b(pres_b), .i_sens_type_a(typ_a), .i_sens_type_b(typ_b),
		.o_busy(busy), .o_ref_enable(ref_en), .o_zero_active(zero_act),
		.o_cal_a_active(cal_a_act), .o_cal_b_active(cal_b_act),
		.o_req_pending(pend), .o_cycle_done(done));

	rzct_ctrl_model #(.HOLD_CYC(2 * POLL)) ctrl (
		.i_clk_sys(clk), .i_go(go), .i_code(code), .o_in1_n(in1_n), .o_in2_n(in2_n), .o_idle(idle));

	// free running clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// compare one value, case equality so unknowns never match
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	// move to just after the next rising edge, where inputs change
	task automatic step();
		@(posedge clk);
		#1;
	endtask

	// hand one request to the controller model once it is free
	task automatic send(input logic [1:0] c);
		int n;
		n = 0;
		while (idle !== 1'b1 && n < 200) begin
			step();
			n++;
		end
		code = c;
		go = 1'b1;
		step();
		go = 1'b0;
	endtask

	// bounded waits on the design's own signals; n is the cycles spent
	task automatic wait_busy(output int n);
		n = 0;
		while (busy !== 1'b1 && n < 12000) begin
			step();
			n++;
		end
	endtask

	task automatic wait_done(output int n);
		n = 0;
		while (done !== 1'b1 && n < 12000) begin
			step();
			n++;
		end
	endtask

	// one full request: start delay of waitn samples, run of ticks samples, then a clean end
	task automatic run_cycle(input logic [1:0] c, input logic [2:0] kind, input logic refx, input int ticks,
			input int waitn);
		int n;
		send(c);
		n = 0;
		while (pend !== 1'b1 && n < 200) begin
			step();
			n++;
		end
		check(pend, 1'b1, "request pending");
		wait_busy(n);
		check(n >= (waitn - 1) * SAMP && n <= waitn * SAMP + 3, 1'b1, "start delay");
		check({zero_act, cal_a_act, cal_b_act}, kind, "cycle kind");
		check(ref_en, refx, "reference on");
		wait_done(n);
		check(n >= ticks * SAMP - SAMP && n <= ticks * SAMP + 2, 1'b1, "run length");
		check(busy, 1'b0, "busy end");
		check(ref_en, 1'b0, "reference off");
		step();
		check(done, 1'b0, "done pulse");
	endtask

	// everything quiet after reset, also when reset lands in mid cycle
	task automatic t_reset();
		int n;
		check({busy, ref_en, zero_act, cal_a_act, cal_b_act, pend, done}, 7'h00, "after reset");
		send(rzct_pkg::LVL_CAL_A);
		wait_busy(n);
		rst = 1'b1;
		step();
		step();
		rst = 1'b0;
		check({busy, ref_en, zero_act, cal_a_act, cal_b_act, pend, done}, 7'h00, "mid reset");
	endtask

	// released pins must never start anything
	task automatic t_idle_code();
		send(rzct_pkg::LVL_NONE);
		repeat (5 * POLL) step();
		check({pend, busy}, 2'h0, "no request");
	endtask

	// every sensor family on channel B, channel A on the plainest family
	task automatic t_cal_types();
		int cal_s[4];
		cal_s = '{rzct_pkg::CAL_S_THERM, rzct_pkg::CAL_S_DIODE, rzct_pkg::CAL_S_NEW, rzct_pkg::CAL_S_NEWCF};
		run_cycle(rzct_pkg::LVL_CAL_A, 3'h2, 1'b1, cal_s[0] * TPS, 1);
		for (int t = 0; t < 4; t++) begin
			typ_b = t[1:0];
			run_cycle(rzct_pkg::LVL_CAL_B, 3'h1, 1'b1, cal_s[t] * TPS, 1);
		end
	endtask

	// zero both sums its sensors; with none attached it is one sample long
	task automatic t_zero_both();
		typ_a = 2'h1;
		typ_b = 2'h3;
		run_cycle(rzct_pkg::LVL_ZERO, 3'h4, 1'b0, (rzct_pkg::ZERO_S_DIODE + rzct_pkg::ZERO_S_NEWCF) * TPS, 1);
		pres_a = 1'b0;
		pres_b = 1'b0;
		run_cycle(rzct_pkg::LVL_ZERO, 3'h4, 1'b0, 1, 1);
		pres_a = 1'b1;
		pres_b = 1'b1;
	endtask

	// outside free run the start waits for the averaging period; zero reads as one, big counts clamp
	task automatic t_avg_wait();
		free_run = 1'b0;
		avg = 11'h004;
		run_cycle(rzct_pkg::LVL_CAL_A, 3'h2, 1'b1, rzct_pkg::CAL_S_DIODE * TPS, 4);
		avg = 11'h000;
		run_cycle(rzct_pkg::LVL_CAL_A, 3'h2, 1'b1, rzct_pkg::CAL_S_DIODE * TPS, 1);
		avg = 11'h7FF;
		run_cycle(rzct_pkg::LVL_CAL_A, 3'h2, 1'b1, rzct_pkg::CAL_S_DIODE * TPS, rzct_pkg::MAX_AVG);
		free_run = 1'b1;
	endtask

	// a request made during a run starts at once when that run ends
	task automatic t_queued();
		int n;
		typ_a = 2'h0;
		pres_b = 1'b0;
		send(rzct_pkg::LVL_CAL_A);
		wait_busy(n);
		send(rzct_pkg::LVL_ZERO);
		repeat (3 * POLL) step();
		check(pend, 1'b1, "queued pending");
		wait_done(n);
		check(busy, 1'b1, "queued start");
		step();
		check({zero_act, cal_a_act, ref_en}, 3'h4, "queued kind");
		wait_done(n);
		check(n >= (rzct_pkg::ZERO_S_THERM * TPS - 1) * SAMP && n <= rzct_pkg::ZERO_S_THERM * TPS * SAMP + 2,
			1'b1, "queued length");
		pres_b = 1'b1;
	endtask

	// counts, verdict and end of run
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// main sequence: inputs change 1 ns after each rising edge
	initial begin
		rst = 1'b1;
		go = 1'b0;
		code = 2'h3;
		free_run = 1'b1;
		avg = 11'h001;
		pres_a = 1'b1;
		pres_b = 1'b1;
		typ_a = 2'h0;
		typ_b = 2'h0;
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_idle_code();
		t_cal_types();
		t_zero_both();
		t_avg_wait();
		t_queued();
		give_verdict();
	end

	// watchdog well beyond the roughly 30,000 cycles the tests need
	initial begin
		#600000;
		n_errors++;
		give_verdict();
	end
endmodule
